//--- core/tcd_dma.sv
// Local design decisions: the APB register port and the register offsets.
`timescale 1ns/1ps
module tcd_dma
  import tcd_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic pready,
  output logic [31:0] prdata,
  output logic pslverr,
  input wire logic link_clk,
  input wire logic ser_rxd,
  input wire logic ser_receive_frame_sync,
  input wire logic ser_oof,
  output logic ser_txd
);
  tcd_mem_if tx_m ();
  tcd_mem_if rx_m ();
  tcd_fifo_mem u_tx_mem (.pclk(pclk), .port(tx_m.mem));
  tcd_fifo_mem u_rx_mem (.pclk(pclk), .port(rx_m.mem));

  // two-stage synchronisers for pin inputs
  logic [3:0] raw;
  logic [3:0] s1_r;
  logic [3:0] s2_r;
  logic [3:0] prev_r;
  assign raw = {ser_oof, ser_receive_frame_sync, ser_rxd, link_clk};
  generate
    for (genvar i = 0; i < 4; i++) begin : g_sync
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          s1_r[i] <= 1'b0;
          s2_r[i] <= 1'b0;
          prev_r[i] <= 1'b0;
        end else begin
          s1_r[i] <= raw[i];
          s2_r[i] <= s1_r[i];
          prev_r[i] <= s2_r[i];
        end
      end
    end
  endgenerate
  logic lclk_rise, lclk_fall, oof_rise, oof_fall, oof_now;
  assign lclk_rise = s2_r[0] & ~prev_r[0];
  assign lclk_fall = ~s2_r[0] & prev_r[0];
  assign oof_now = s2_r[3];
  assign oof_rise = s2_r[3] & ~prev_r[3];
  assign oof_fall = ~s2_r[3] & prev_r[3];

  // state
  logic pready_r, pslverr_r, ser_txd_r;
  logic [31:0] prdata_r;
  logic [15:0] ctrl_r;
  logic [7:0] rxcfg_r;
  logic tx_act_r, rx_act_r, tx_own_r, rx_own_r, tx_note_r, rx_note_r, tx_live_r;
  logic [15:0] tx_rem_r, rx_rem_r;
  logic [ADDR_W:0] tx_wp_r, tx_rp_r, rx_wp_r, rx_rp_r;
  logic [2:0] tx_bit_r, rx_bit_r;
  logic [7:0] tx_sh_r, rx_sh_r;
  logic [10:0] fly_r;
  logic rs_prev_r;
  logic [5:0] evt_r;

  logic [ADDR_W:0] tx_cnt, rx_cnt;
  logic tx_empty, tx_full, rx_empty, rx_full, abort_sel;
  logic [2:0] mode;
  assign tx_cnt = tx_wp_r - tx_rp_r;
  assign rx_cnt = rx_wp_r - rx_rp_r;
  assign tx_empty = (tx_cnt == '0);
  assign tx_full = (tx_cnt == DEPTH);
  assign rx_empty = (rx_cnt == '0);
  assign rx_full = (rx_cnt == DEPTH);
  assign abort_sel = ctrl_r[CTL_ABORT_SEL];
  assign mode = ctrl_r[CTL_MODE_LSB +: 3];

  // apb: one wait state, access completes when pready_r is high
  logic acc, wr_acc, rd_acc, pre;
  assign pre = psel & penable & ~pready_r;
  assign acc = psel & penable & pready_r;
  assign wr_acc = acc & pwrite;
  assign rd_acc = acc & ~pwrite;

  // transfer conditions seen by the bus and the link
  logic tx_push, rx_pop, tx_pop, tx_fault, rx_octet, rx_ovf, frame_alignment_change, rx_flush;
  logic [10:0] frm_len;
  assign tx_push = wr_acc & (paddr == OFS_TXDATA) & tx_act_r & tx_own_r & (tx_rem_r != '0) & ~tx_full;
  assign rx_pop = rd_acc & (paddr == OFS_RXDATA) & rx_own_r & (rx_rem_r != '0) & ~rx_empty;
  assign tx_pop = lclk_fall & tx_act_r & (tx_bit_r == '0) & ~tx_empty;
  assign tx_fault = lclk_fall & tx_act_r & (tx_bit_r == '0) & tx_empty;
  assign rx_octet = lclk_rise & rx_act_r & (rx_bit_r == 3'h7);
  assign rx_ovf = rx_octet & rx_full;
  always_comb begin
    unique case (mode)
      MODE_T1: frm_len = FRM_T1;
      MODE_E1: frm_len = FRM_E1;
      MODE_2E1: frm_len = FRM_2E1;
      MODE_4E1: frm_len = FRM_4E1;
      default: frm_len = '0;
    endcase
  end
  assign frame_alignment_change = lclk_rise & s2_r[2] & ~rs_prev_r & (frm_len != '0) & (fly_r != frm_len - 11'h1);
  assign rx_flush = rx_ovf | oof_rise | (frame_alignment_change & abort_sel);

  tcd_ev_t ev_code;
  logic ev_dir;
  // one event entry per cycle, errors before notices
  always_comb begin
    ev_code = EV_NONE;
    ev_dir = DIR_RX;
    if (tx_fault) begin
      ev_code = tx_own_r ? EV_STARVE : EV_OWN_FAULT;
      ev_dir = DIR_TX;
    end else if (rx_ovf) begin
      ev_code = rx_own_r ? EV_STARVE : EV_OWN_FAULT;
    end else if (oof_rise) begin
      ev_code = EV_FRM_LOSS;
    end else if (frame_alignment_change) begin
      ev_code = EV_ALIGN_CHG;
    end else if (oof_fall & ~ctrl_r[CTL_LOSS_MASK]) begin
      ev_code = EV_FRM_REGAIN;
    end else if (tx_push & (tx_rem_r == 16'h1) & tx_note_r) begin
      ev_code = EV_END_BUF;
      ev_dir = DIR_TX;
    end else if (rx_pop & (rx_rem_r == 16'h1) & rx_note_r) begin
      ev_code = EV_END_BUF;
    end
  end

  // event register, a new entry wins over the read clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      evt_r <= '0;
    end else if (ev_code != EV_NONE) begin
      evt_r <= {ev_code, ev_dir, 1'b1};
    end else if (rd_acc & (paddr == OFS_EVENT)) begin
      evt_r[0] <= 1'b0;
    end
  end

  // apb handshake and read data
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r <= '0;
    end else begin
      pready_r <= pre;
      pslverr_r <= 1'b0;
      prdata_r <= '0;
      if (pre) begin
        unique case (paddr)
          OFS_CTRL: prdata_r <= {16'h0, ctrl_r};
          OFS_CMD: prdata_r <= '0;
          OFS_RXCFG: prdata_r <= {24'h0, rxcfg_r};
          OFS_TXDESC: prdata_r <= {tx_own_r, 14'h0, tx_note_r, tx_rem_r};
          OFS_RXDESC: prdata_r <= {rx_own_r, 14'h0, rx_note_r, rx_rem_r};
          OFS_TXDATA: pslverr_r <= pwrite & (tx_full | ~tx_act_r | ~tx_own_r);
          OFS_RXDATA: prdata_r <= {24'h0, (rx_own_r & ~rx_empty) ? rx_m.rd_data : 8'h0};
          OFS_STATUS: prdata_r <= {16'h0, oof_now, 3'h0, rx_cnt, 2'h0, rx_act_r, tx_act_r, tx_cnt};
          OFS_EVENT: prdata_r <= {26'h0, evt_r};
          default: pslverr_r <= 1'b1;
        endcase
      end
    end
  end

  // configuration and activation
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_r <= CTRL_RST;
      rxcfg_r <= '0;
      tx_act_r <= 1'b0;
      rx_act_r <= 1'b0;
    end else begin
      if (wr_acc & (paddr == OFS_CTRL)) begin
        ctrl_r <= pwdata[15:0];
      end
      if (wr_acc & (paddr == OFS_RXCFG)) begin
        rxcfg_r <= pwdata[7:0];
      end
      // a fault drops the channel; only host activation brings it back
      if (tx_fault) begin
        tx_act_r <= 1'b0;
      end else if (wr_acc & (paddr == OFS_CMD) & pwdata[CMD_TX_ACT]) begin
        tx_act_r <= ctrl_r[CTL_TX_TRANSP];
      end
      if (rx_ovf | (oof_rise & abort_sel) | (frame_alignment_change & abort_sel)) begin
        rx_act_r <= 1'b0;
      end else if (wr_acc & (((paddr == OFS_CMD) & (pwdata[CMD_RX_ACT] | pwdata[CMD_RX_JUMP]))
                             | (paddr == OFS_RXCFG))) begin
        rx_act_r <= ctrl_r[CTL_RX_TRANSP];
      end
    end
  end

  // transmit descriptor: end_of_message and extras are stored nowhere
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_own_r <= 1'b0;
      tx_note_r <= 1'b0;
      tx_rem_r <= '0;
      tx_wp_r <= '0;
    end else if (wr_acc & (paddr == OFS_TXDESC)) begin
      tx_own_r <= pwdata[DSC_OWNER] & (pwdata[15:0] != '0);
      tx_note_r <= pwdata[DSC_NOTIFY];
      tx_rem_r <= pwdata[15:0];
    end else if (tx_push) begin
      tx_wp_r <= tx_wp_r + 4'h1;
      tx_rem_r <= tx_rem_r - 16'h1;
      if (tx_rem_r == 16'h1) begin
        tx_own_r <= 1'b0;
      end
    end
  end
  assign tx_m.wr_en = tx_push;
  assign tx_m.wr_addr = tx_wp_r[ADDR_W-1:0];
  assign tx_m.wr_data = pwdata[7:0];
  assign tx_m.rd_addr = tx_rp_r[ADDR_W-1:0];

  // transmit serialiser, msb first, idle code when not carrying data
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_bit_r <= '0;
      tx_sh_r <= '0;
      tx_live_r <= 1'b0;
      tx_rp_r <= '0;
      ser_txd_r <= 1'b1;
    end else if (lclk_fall) begin
      tx_bit_r <= tx_bit_r + 3'h1;
      if (tx_pop) begin
        tx_rp_r <= tx_rp_r + 4'h1;
        tx_sh_r <= {tx_m.rd_data[6:0], 1'b0};
        ser_txd_r <= tx_m.rd_data[7];
        tx_live_r <= 1'b1;
      end else if (tx_live_r & (tx_bit_r != '0)) begin
        tx_sh_r <= {tx_sh_r[6:0], 1'b0};
        ser_txd_r <= tx_sh_r[7];
      end else begin
        tx_live_r <= 1'b0;
        ser_txd_r <= ctrl_r[CTL_IDLE_LSB + 7 - tx_bit_r];
      end
    end
  end

  // receive descriptor and drain
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_own_r <= 1'b0;
      rx_note_r <= 1'b0;
      rx_rem_r <= '0;
      rx_rp_r <= '0;
    end else begin
      if (wr_acc & (paddr == OFS_RXDESC)) begin
        rx_own_r <= pwdata[DSC_OWNER] & (pwdata[15:0] != '0);
        rx_note_r <= pwdata[DSC_NOTIFY];
        rx_rem_r <= pwdata[15:0];
      end else if (rx_pop & ~rx_flush) begin
        rx_rem_r <= rx_rem_r - 16'h1;
        if (rx_rem_r == 16'h1) begin
          rx_own_r <= 1'b0;
        end
      end
      if (rx_flush) begin
        rx_rp_r <= rx_wp_r;
      end else if (rx_pop) begin
        rx_rp_r <= rx_rp_r + 4'h1;
      end
    end
  end

  // receive deserialiser and frame flywheel
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_bit_r <= '0;
      rx_sh_r <= '0;
      rx_wp_r <= '0;
      fly_r <= '0;
      rs_prev_r <= 1'b0;
    end else if (lclk_rise) begin
      rs_prev_r <= s2_r[2];
      if ((s2_r[2] & ~rs_prev_r) | (fly_r == frm_len - 11'h1)) begin
        fly_r <= '0;
      end else begin
        fly_r <= fly_r + 11'h1;
      end
      if (~rx_act_r | (frame_alignment_change & abort_sel) | (oof_now & abort_sel)) begin
        rx_bit_r <= '0;
      end else begin
        rx_bit_r <= rx_bit_r + 3'h1;
        rx_sh_r <= {rx_sh_r[6:0], oof_now | s2_r[1]};
        if (rx_octet & ~rx_full & ~oof_rise) begin
          rx_wp_r <= rx_wp_r + 4'h1;
        end
      end
    end
  end
  assign rx_m.wr_en = rx_octet & ~rx_full & ~oof_rise & ~(frame_alignment_change & abort_sel);
  assign rx_m.wr_addr = rx_wp_r[ADDR_W-1:0];
  assign rx_m.wr_data = {rx_sh_r[6:0], oof_now | s2_r[1]};
  assign rx_m.rd_addr = rx_rp_r[ADDR_W-1:0];

  assign pready = pready_r;
  assign prdata = prdata_r;
  assign pslverr = pslverr_r;
  assign ser_txd = ser_txd_r;

  a_tx_fault_stop: assert property (@(posedge pclk) disable iff (!presetn)
    tx_fault |=> !tx_act_r) else $error("transmit stayed active after fault");
  a_tx_fault_evt: assert property (@(posedge pclk) disable iff (!presetn)
    tx_fault && !tx_own_r |=> evt_r == {EV_OWN_FAULT, DIR_TX, 1'b1}) else $error("missing transmit ownership entry");
  a_tx_starve_evt: assert property (@(posedge pclk) disable iff (!presetn)
    tx_fault && tx_own_r |=> evt_r == {EV_STARVE, DIR_TX, 1'b1}) else $error("missing transmit starve entry");
  a_tx_no_poll: assert property (@(posedge pclk) disable iff (!presetn)
    !tx_act_r && !(wr_acc && paddr == OFS_CMD) |=> !tx_act_r) else $error("transmit woke without host");
  a_rx_ovf_stop: assert property (@(posedge pclk) disable iff (!presetn)
    rx_ovf |=> !rx_act_r && rx_cnt == '0) else $error("receive overflow not flushed");
  a_oof_flush: assert property (@(posedge pclk) disable iff (!presetn)
    oof_rise |=> rx_cnt == '0 && evt_r[5:1] == {EV_FRM_LOSS, DIR_RX}) else $error("framing loss not handled");
  a_frame_alignment_change_abort: assert property (@(posedge pclk) disable iff (!presetn)
    frame_alignment_change && abort_sel |=> !rx_act_r) else $error("alignment change did not suspend");
  a_rx_reactivate: assert property (@(posedge pclk) disable iff (!presetn)
    wr_acc && paddr == OFS_RXCFG && ctrl_r[CTL_RX_TRANSP] && !rx_flush |=> rx_act_r)
    else $error("config write did not reactivate");
  a_tx_eob: assert property (@(posedge pclk) disable iff (!presetn)
    tx_push && tx_rem_r == 16'h1 |=> !tx_own_r) else $error("transmit descriptor not released");
  a_bus_wait: assert property (@(posedge pclk) disable iff (!presetn)
    pre |=> pready ##1 !pready) else $error("bus answer timing wrong");
endmodule

//--- common/tcd_pkg.sv
package tcd_pkg;
  // storage geometry
  localparam int DATA_W = 8;
  localparam int ADDR_W = 3;
  localparam logic [ADDR_W:0] DEPTH = 4'h8;
  // register byte offsets
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_CMD = 8'h04;
  localparam logic [7:0] OFS_RXCFG = 8'h08;
  localparam logic [7:0] OFS_TXDESC = 8'h0c;
  localparam logic [7:0] OFS_RXDESC = 8'h10;
  localparam logic [7:0] OFS_TXDATA = 8'h14;
  localparam logic [7:0] OFS_RXDATA = 8'h18;
  localparam logic [7:0] OFS_STATUS = 8'h1c;
  localparam logic [7:0] OFS_EVENT = 8'h20;
  // control field positions
  localparam int CTL_TX_TRANSP = 0;
  localparam int CTL_RX_TRANSP = 1;
  localparam int CTL_ABORT_SEL = 2;
  localparam int CTL_LOSS_MASK = 3;
  localparam int CTL_MODE_LSB = 4;
  localparam int CTL_IDLE_LSB = 8;
  localparam logic [15:0] CTRL_RST = 16'hff00;
  // command bits
  localparam int CMD_TX_ACT = 0;
  localparam int CMD_RX_ACT = 1;
  localparam int CMD_RX_JUMP = 2;
  // descriptor field positions
  localparam int DSC_NOTIFY = 16;
  localparam int DSC_END_MSG = 17;
  localparam int DSC_OWNER = 31;
  // port framing modes and flywheel frame lengths in bits
  localparam logic [2:0] MODE_NONE = 3'h0;
  localparam logic [2:0] MODE_T1 = 3'h1;
  localparam logic [2:0] MODE_E1 = 3'h2;
  localparam logic [2:0] MODE_2E1 = 3'h3;
  localparam logic [2:0] MODE_4E1 = 3'h4;
  localparam logic [10:0] FRM_T1 = 11'h0c1;
  localparam logic [10:0] FRM_E1 = 11'h100;
  localparam logic [10:0] FRM_2E1 = 11'h200;
  localparam logic [10:0] FRM_4E1 = 11'h400;
  // event codes
  typedef enum logic [3:0] {
    EV_NONE, EV_END_BUF, EV_FRM_REGAIN, EV_OWN_FAULT,
    EV_STARVE, EV_ALIGN_CHG, EV_FRM_LOSS
  } tcd_ev_t;
  localparam logic DIR_TX = 1'b1;
  localparam logic DIR_RX = 1'b0;
endpackage

//--- common/tcd_mem_if.sv
`timescale 1ns/1ps
interface tcd_mem_if;
  import tcd_pkg::*;
  logic wr_en;
  logic [ADDR_W-1:0] wr_addr;
  logic [DATA_W-1:0] wr_data;
  logic [ADDR_W-1:0] rd_addr;
  logic [DATA_W-1:0] rd_data;
  modport mem (input wr_en, input wr_addr, input wr_data, input rd_addr, output rd_data);
  modport ctl (output wr_en, output wr_addr, output wr_data, output rd_addr, input rd_data);
endinterface

//--- core/tcd_fifo_mem.sv
`timescale 1ns/1ps
module tcd_fifo_mem
  import tcd_pkg::*;
(
  input wire logic pclk,
  tcd_mem_if.mem port
);
  logic [DATA_W-1:0] mem_r [0:DEPTH-1];

  // write port, registered read port
  always_ff @(posedge pclk) begin
    if (port.wr_en) begin
      mem_r[port.wr_addr] <= port.wr_data;
    end
    port.rd_data <= mem_r[port.rd_addr];
  end
endmodule

//--- tb/tcd_framer_model.sv
`timescale 1ns/1ps
// serial framer partner: clocks the link only inside frames
module tcd_framer_model (
  output logic link_clk,
  output logic ser_rxd,
  output logic ser_receive_frame_sync,
  input wire logic ser_txd
);
  logic tx_q[$];

  // idle levels before the first frame
  initial begin
    link_clk = 1'b0;
    ser_rxd = 1'b1;
    ser_receive_frame_sync = 1'b0;
  end

  // one frame: rx bits msb first, changed while the clock is low
  task automatic run(input int n, input logic [127:0] bits, input logic [127:0] sync);
    for (int i = 0; i < n; i++) begin
      ser_rxd = bits[n-1-i];
      ser_receive_frame_sync = sync[n-1-i];
      #62.5 link_clk = 1'b1;
      tx_q.push_back(ser_txd); // mid bit sample
      #62.5 link_clk = 1'b0;
    end
    ser_rxd = ~ser_rxd; // released line shows no stale value
    ser_receive_frame_sync = 1'b0;
  endtask
endmodule

//--- tb/tb_top.sv
`timescale 1ns/1ps
module tb_top
  import tcd_pkg::*;
;
  logic pclk, presetn, psel, penable, pwrite, ser_oof, pready, pslverr, ser_txd;
  logic link_clk, ser_rxd, ser_receive_frame_sync, err_v;
  logic [7:0] paddr, d0, d1;
  logic [31:0] pwdata, prdata, rd_v;
  logic [7:0] exp_q[$];
  int seed = 12;
  int checks = 0;
  int miscompares = 0;
  int k;

  tcd_dma uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .link_clk(link_clk), .ser_rxd(ser_rxd), .ser_receive_frame_sync(ser_receive_frame_sync), .ser_oof(ser_oof), .ser_txd(ser_txd));
  tcd_framer_model fr (.link_clk(link_clk), .ser_rxd(ser_rxd), .ser_receive_frame_sync(ser_receive_frame_sync), .ser_txd(ser_txd));

  // bus clock
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end

  // compare and count
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      miscompares++;
      $display("mismatch at %0t got %h expected %h", $time, got, exp);
    end
  endtask

  // one apb transfer, held until pready is sampled high
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 40);
    rd_v = prdata;
    err_v = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 40) chk(32'h0, 32'h1);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  task automatic rdc(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(rd_v & m, e);
  endtask

  // queue n random octets for transmit, first one starting with a zero bit
  task automatic push(input int n);
    exp_q.delete();
    for (int i = 0; i < n; i++) begin
      d0 = 8'($random(seed)) & ((i == 0) ? 8'h7f : 8'hff);
      exp_q.push_back(d0);
      wr(OFS_TXDATA, {24'h0, d0});
      chk({31'h0, err_v}, 32'h0);
    end
  endtask

  // one link frame, then let the synchroniser settle
  task automatic frame(input int n, input logic [127:0] bits, input logic [127:0] sync);
    fr.tx_q.delete();
    fr.run(n, bits, sync);
    repeat (8) @(posedge pclk);
  endtask

  // tx stream after the idle ones must be the queued octets, then idle again
  task automatic txcmp();
    int nb;
    nb = 8 * exp_q.size();
    k = 0;
    while (k < fr.tx_q.size() && fr.tx_q[k] === 1'b1) k++;
    for (int i = 0; i < nb + 8; i++) begin
      chk({31'h0, fr.tx_q[k+i]}, (i < nb) ? {31'h0, exp_q[i/8][7-i%8]} : 32'h1);
    end
  endtask

  task automatic setoof(input logic v);
    @(posedge pclk);
    ser_oof <= v;
    repeat (8) @(posedge pclk);
  endtask

  task automatic print_verdict();
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  // watchdog
  initial begin
    #200000;
    miscompares++;
    print_verdict();
  end

  // main sequence
  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    ser_oof = 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    rdc(OFS_CTRL, 32'hffff, {16'h0, CTRL_RST});
    apb(1'b0, 8'hfc, 32'h0);
    chk({31'h0, err_v}, 32'h1);
    wr(OFS_TXDATA, 32'h5a);
    chk({31'h0, err_v}, 32'h1);
    wr(OFS_CTRL, 32'hff02);
    wr(OFS_CMD, 32'h1);
    rdc(OFS_STATUS, 32'h30, 32'h0);
    $display("test registers done");
    // transmit a two octet buffer, then run dry on a host-owned one
    wr(OFS_CTRL, 32'hff03);
    wr(OFS_TXDESC, 32'h8001_0002);
    // data is only taken while the channel is active; the stopped link clock keeps it from running dry
    wr(OFS_CMD, 32'h1);
    rdc(OFS_STATUS, 32'h10, 32'h10);
    push(2);
    rdc(OFS_EVENT, 32'h3f, 32'h07);
    rdc(OFS_EVENT, 32'h01, 32'h00);
    frame(48, '1, '0);
    txcmp();
    rdc(OFS_EVENT, 32'h3f, 32'h0f);
    rdc(OFS_STATUS, 32'h10, 32'h0);
    // starve with an owned buffer, recover and drain
    wr(OFS_TXDESC, 32'h8000_0003);
    wr(OFS_CMD, 32'h1);
    push(1);
    frame(32, '1, '0);
    txcmp();
    rdc(OFS_EVENT, 32'h3f, 32'h13);
    rdc(OFS_STATUS, 32'h10, 32'h0);
    wr(OFS_CMD, 32'h1);
    rdc(OFS_STATUS, 32'h10, 32'h10);
    push(2);
    frame(40, '1, '0);
    txcmp();
    rdc(OFS_EVENT, 32'h3f, 32'h0f);
    $display("test transmit done");
    // receive one buffer of two octets
    wr(OFS_RXDESC, 32'h8001_0002);
    wr(OFS_CMD, 32'h2);
    rdc(OFS_STATUS, 32'h20, 32'h20);
    d0 = 8'($random(seed));
    d1 = 8'($random(seed));
    frame(16, {112'h0, d0, d1}, '0);
    rdc(OFS_RXDATA, 32'hff, {24'h0, d0});
    rdc(OFS_RXDATA, 32'hff, {24'h0, d1});
    rdc(OFS_EVENT, 32'h3f, 32'h05);
    rdc(OFS_RXDATA, 32'hff, 32'h0);
    // overflow without and with an owned buffer, each reactivation path
    for (int m = 0; m < 4; m++) begin
      if (m == 3) wr(OFS_RXDESC, 32'h8000_0010);
      frame(72, {32'h0, $random(seed), $random(seed), $random(seed)}, '0);
      rdc(OFS_EVENT, 32'h3f, (m == 3) ? 32'h11 : 32'h0d);
      rdc(OFS_STATUS, 32'hf20, 32'h0);
      if (m == 1) wr(OFS_CMD, 32'h4);
      else if (m == 2) wr(OFS_RXCFG, 32'h5a);
      else wr(OFS_CMD, 32'h2);
      rdc(OFS_STATUS, 32'h20, 32'h20);
    end
    $display("test receive done");
    // loss of framing, abort select clear then set
    wr(OFS_RXDESC, 32'h8000_0004);
    frame(8, 128'h5a, '0);
    setoof(1'b1);
    rdc(OFS_EVENT, 32'h3f, 32'h19);
    rdc(OFS_STATUS, 32'h8f20, 32'h8020);
    frame(8, 128'h0, '0);
    rdc(OFS_RXDATA, 32'hff, 32'hff);
    setoof(1'b0);
    rdc(OFS_EVENT, 32'h3f, 32'h09);
    rdc(OFS_STATUS, 32'h20, 32'h20);
    wr(OFS_CTRL, 32'hff07);
    setoof(1'b1);
    rdc(OFS_EVENT, 32'h3f, 32'h19);
    rdc(OFS_STATUS, 32'h20, 32'h0);
    wr(OFS_CTRL, 32'hff0f);
    setoof(1'b0);
    rdc(OFS_EVENT, 32'h01, 32'h0);
    wr(OFS_CMD, 32'h2);
    rdc(OFS_STATUS, 32'h20, 32'h20);
    $display("test framing loss done");
    // early frame sync in every framed mode, ignored when unframed
    for (int m = 0; m < 5; m++) begin
      wr(OFS_CTRL, 32'hff03 | (32'(m) << 4));
      frame(8, 128'h0, 128'h44);
      rdc(OFS_EVENT, (m == 0) ? 32'h01 : 32'h3f, (m == 0) ? 32'h0 : 32'h15);
      rdc(OFS_STATUS, 32'h20, 32'h20);
    end
    wr(OFS_CTRL, 32'hff27);
    frame(8, 128'h0, 128'h44);
    rdc(OFS_EVENT, 32'h3f, 32'h15);
    rdc(OFS_STATUS, 32'h20, 32'h0);
    wr(OFS_RXCFG, 32'h0);
    rdc(OFS_STATUS, 32'h20, 32'h20);
    $display("test alignment done");
    print_verdict();
  end
endmodule
